//--- processor_sideband_control.sv
`default_nettype none
module processor_sideband_control
  import sideband_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output var  logic [31:0]          reg_rdata,
  input  wire logic                 io_write,
  input  wire logic [15:0]          io_addr,
  input  wire logic                 numeric_error_in_n,
  output var  logic                 ignore_error_out_n,
  output var  logic                 internal_irq_thirteen,
  input  wire logic                 serr_internal,
  input  wire logic                 serr_pin_n,
  input  wire logic                 serr_hub_msg,
  input  wire logic                 iochk_serial,
  output var  logic                 nmi_out,
  output var  logic                 sci_out,
  input  wire logic                 platform_power_ok,
  input  wire logic                 regulator_power_good,
  output var  logic                 proc_power_good_out,
  input  wire logic                 stop_grant_seen,
  input  wire logic                 break_event,
  input  wire logic                 power_returned,
  output var  logic                 stop_clock_request_n,
  output var  logic                 deeper_sleep_n,
  output var  logic                 proc_clock_stop_n,
  output var  logic                 low_voltage_req,
  output var  logic                 sleep_out_n,
  output var  logic                 mem_access_block,
  output var  logic                 clocks_stopped,
  output var  logic                 resume_to_s0
);
  import sideband_pkg::*;
  localparam logic [15:0] CLEAR_PORT = 16'h00f0;

  logic [31:0] ctrl_q;
  logic [2:0]  cmd_q;
  logic [31:0] rdata_d;
  logic        irq_q, ign_q, prior_on_q, throttle_q;
  logic [3:0]  cnt_q;
  pm_state_t   st_q, st_d;
  wire logic   err_act   = ~numeric_error_in_n;
  wire logic   en        = ctrl_q[CTRL_COPROC_EN];
  wire logic   route_sci = ctrl_q[CTRL_NMI_SCI];
  wire logic   wr_ctrl   = reg_write && reg_addr == OFF_CTRL;
  wire logic   wr_cmd    = reg_write && reg_addr == OFF_CMD;
  // Only the strobe and address decode; data is ignored
  wire logic   clr_write = io_write && io_addr == CLEAR_PORT;
  wire logic   sys_err   = serr_internal | ~serr_pin_n | serr_hub_msg;
  wire logic   nmi_src   = sys_err | iochk_serial;
  wire logic   cnt_done  = cnt_q == 4'h0;

  assign rdata_d = (reg_addr == OFF_CTRL)   ? ctrl_q :
                   (reg_addr == OFF_CMD)    ? {29'h0, cmd_q} :
                   (reg_addr == OFF_STATUS) ? {24'h0, st_q, ign_q, irq_q, ~numeric_error_in_n,
                                               1'b0} :
                   32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q    <= CTRL_RESET;
      cmd_q     <= CMD_C0;
      reg_rdata <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_cmd) cmd_q <= reg_wdata[CMD_W-1:0];
      reg_rdata <= reg_read ? rdata_d : 32'h0;
    end
  end

  // Coprocessor error handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      ign_q <= 1'b0;
    end else begin
      // Error still active and not yet acknowledged keeps INTERNAL_IRQ_THIRTEEN up
      irq_q <= en && err_act && !ign_q && !clr_write;
      if (!err_act || !en) ign_q <= 1'b0;
      else if (clr_write) ign_q <= 1'b1;
    end
  end
  assign internal_irq_thirteen = irq_q;
  // Gating with the live pin guarantees release on the same edge it is seen
  always_ff @(posedge clk) begin
    if (rst) ignore_error_out_n <= 1'b1;
    else ignore_error_out_n <= !(en && err_act && (ign_q || clr_write));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_out             <= 1'b0;
      sci_out             <= 1'b0;
      proc_power_good_out <= 1'b0;
    end else begin
      nmi_out             <= nmi_src && !route_sci;
      sci_out             <= nmi_src && route_sci;
      proc_power_good_out <= platform_power_ok && regulator_power_good;
    end
  end

  // Power state sequencer; timed steps wait STEP_GAP_CYC so edges stay ordered, the others wait for command, grant, break or power events
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_C0:
        if (cmd_q != CMD_C0 || throttle_q) st_d = ST_STOP_CLOCK_REQUEST_N;
      ST_STOP_CLOCK_REQUEST_N:
        if (stop_grant_seen) st_d = ST_GRANTED;
        else if (cmd_q == CMD_C0 && !throttle_q) st_d = ST_C0;
      ST_GRANTED:
        if (cmd_q == CMD_C3 || cmd_q == CMD_C4) st_d = ST_DEEPER_SLEEP_N;
        else if (cmd_q == CMD_S1 || cmd_q == CMD_S3) st_d = ST_SLEEP;
        else if (break_event || cmd_q == CMD_C0) st_d = ST_C0;
      ST_DEEPER_SLEEP_N:
        if (cnt_done) st_d = ST_STOPCPU;
      ST_STOPCPU:
        if (break_event) st_d = ST_CLKRUN;
        else if (cnt_done && cmd_q == CMD_C4) st_d = ST_LOWV;
      ST_LOWV:
        if (break_event) st_d = ST_RAISEV;
      ST_RAISEV:
        if (cnt_done) st_d = ST_CLKRUN;
      ST_CLKRUN:
        if (cnt_done) st_d = ST_DEEPER_SLEEP_N_OFF;
      ST_DEEPER_SLEEP_N_OFF:
        if (cnt_done) st_d = ST_C0;
      ST_SLEEP:
        if (cmd_q == CMD_S3 && cnt_done) st_d = ST_SUSPEND;
        else if (break_event) st_d = ST_C0;
      ST_SUSPEND:
        if (power_returned) st_d = ST_C0;
      default: st_d = ST_C0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q       <= ST_C0;
      cnt_q      <= STEP_GAP_CYC;
      throttle_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? STEP_GAP_CYC : (cnt_done ? cnt_q : cnt_q - 4'h1);
      // Throttle request: single pulse of stop-clock when written in C0
      throttle_q <= wr_cmd && reg_wdata[3] ? 1'b1 : (st_q == ST_GRANTED ? 1'b0 : throttle_q);
    end
  end

  // After power loss: resume to S0 if C0 was seen after the last ST_SUSPEND, unless the CTRL_AFTER_G3 bit says stay off
  always_ff @(posedge clk) begin
    if (rst) begin
      prior_on_q   <= 1'b0;
      resume_to_s0 <= 1'b0;
    end else begin
      if (st_q == ST_C0) prior_on_q <= 1'b1;
      else if (st_q == ST_SUSPEND) prior_on_q <= 1'b0;
      resume_to_s0 <= power_returned && prior_on_q && !ctrl_q[CTRL_AFTER_G3];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_clock_request_n <= 1'b1;
      deeper_sleep_n       <= 1'b1;
      proc_clock_stop_n    <= 1'b1;
      low_voltage_req      <= 1'b0;
      sleep_out_n          <= 1'b1;
      mem_access_block     <= 1'b0;
      clocks_stopped       <= 1'b0;
    end else begin
      stop_clock_request_n <= st_d == ST_C0;
      deeper_sleep_n       <= !(st_d inside {ST_DEEPER_SLEEP_N, ST_STOPCPU, ST_LOWV, ST_RAISEV,
                                             ST_CLKRUN});
      proc_clock_stop_n    <= !(st_d inside {ST_STOPCPU, ST_LOWV, ST_RAISEV});
      low_voltage_req      <= st_d == ST_LOWV;
      sleep_out_n          <= !(cmd_q == CMD_S3 && st_d inside {ST_SLEEP, ST_SUSPEND});
      // above: S1 alone leaves sleep inactive
      mem_access_block     <= st_d inside {ST_DEEPER_SLEEP_N, ST_STOPCPU, ST_LOWV, ST_RAISEV};
      clocks_stopped       <= st_d == ST_SUSPEND;
    end
  end

  property p_irq_needs_en;
    @(posedge clk) disable iff (rst) internal_irq_thirteen |-> $past(en) && $past(err_act);
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en) else $error("irq without enable");

  property p_irq_rise;
    @(posedge clk) disable iff (rst) (en && err_act && !ign_q && !clr_write) |=> irq_q;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq not raised");

  property p_clear;
    @(posedge clk) disable iff (rst) (en && err_act && clr_write) |=>
      !internal_irq_thirteen && !ignore_error_out_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear port ineffective");

  property p_ign_hold;
    @(posedge clk) disable iff (rst) (!ignore_error_out_n && en && err_act) |=> !ignore_error_out_n;
  endproperty
  a_ign_hold: assert property (p_ign_hold) else $error("ignore dropped early");

  property p_ign_needs_err;
    @(posedge clk) disable iff (rst) !ignore_error_out_n |-> $past(err_act);
  endproperty
  a_ign_needs_err: assert property (p_ign_needs_err) else $error("ignore without error");

  property p_disabled;
    @(posedge clk) disable iff (rst) !en |=> !internal_irq_thirteen && ignore_error_out_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("active while disabled");

  property p_route;
    @(posedge clk) disable iff (rst) nmi_src |=> (nmi_out != sci_out) && (sci_out == $past(route_sci));
  endproperty
  a_route: assert property (p_route) else $error("nmi route wrong");

  property p_pwrgd;
    @(posedge clk) disable iff (rst) 1'b1 |=>
      proc_power_good_out == $past(platform_power_ok && regulator_power_good);
  endproperty
  a_pwrgd: assert property (p_pwrgd) else $error("power good mismatch");

  property p_deeper_sleep_n_wrap;
    @(posedge clk) disable iff (rst) !proc_clock_stop_n |-> !deeper_sleep_n;
  endproperty
  a_deeper_sleep_n_wrap: assert property (p_deeper_sleep_n_wrap) else $error("clock stop outside deep sleep");

  property p_lowv;
    @(posedge clk) disable iff (rst) low_voltage_req |-> !proc_clock_stop_n;
  endproperty
  a_lowv: assert property (p_lowv) else $error("low voltage without clock stop");

  property p_clear_drops_irq;
    @(posedge clk) disable iff (rst)
      clr_write |=> !internal_irq_thirteen;
  endproperty
  a_clear_drops_irq: assert property (p_clear_drops_irq) else $error("irq kept after clear");

  property p_ign_waits_clear;
    @(posedge clk) disable iff (rst)
      (en && err_act && !clr_write && !ign_q) |=> ignore_error_out_n;
  endproperty
  a_ign_waits_clear: assert property (p_ign_waits_clear) else $error("ignore before clear");

  property p_ign_release;
    @(posedge clk) disable iff (rst)
      !err_act |=> ignore_error_out_n;
  endproperty
  a_ign_release: assert property (p_ign_release) else $error("ignore not released");

  property p_irq_gone;
    @(posedge clk) disable iff (rst)
      !err_act |=> !internal_irq_thirteen;
  endproperty
  a_irq_gone: assert property (p_irq_gone) else $error("irq without error");

  property p_sci_sys;
    @(posedge clk) disable iff (rst)
      (sys_err && route_sci) |=> sci_out && !nmi_out;
  endproperty
  a_sci_sys: assert property (p_sci_sys) else $error("system error not routed to sci");

  property p_iochk_nmi;
    @(posedge clk) disable iff (rst)
      (iochk_serial && !route_sci) |=> nmi_out && !sci_out;
  endproperty
  a_iochk_nmi: assert property (p_iochk_nmi) else $error("channel check not nmi");

  property p_quiet;
    @(posedge clk) disable iff (rst)
      !nmi_src |=> !nmi_out && !sci_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("nmi without source");

  property p_throttle;
    @(posedge clk) disable iff (rst)
      (st_q == ST_C0 && throttle_q) |=> !stop_clock_request_n;
  endproperty
  a_throttle: assert property (p_throttle) else $error("throttle pulse missing");

  property p_c2_hold;
    @(posedge clk) disable iff (rst)
      (st_q == ST_GRANTED && cmd_q == CMD_C2) |-> !stop_clock_request_n;
  endproperty
  a_c2_hold: assert property (p_c2_hold) else $error("stop clock dropped in c2");

  property p_deeper_sleep_n_first;
    @(posedge clk) disable iff (rst)
      $fell(proc_clock_stop_n) |-> $past(!deeper_sleep_n);
  endproperty
  a_deeper_sleep_n_first: assert property (p_deeper_sleep_n_first) else $error("clock stop before deep sleep");

  property p_deeper_sleep_n_last;
    @(posedge clk) disable iff (rst)
      $rose(deeper_sleep_n) |-> $past(proc_clock_stop_n);
  endproperty
  a_deeper_sleep_n_last: assert property (p_deeper_sleep_n_last) else $error("deep sleep left too early");

  property p_grant_deeper_sleep_n;
    @(posedge clk) disable iff (rst)
      (st_q == ST_GRANTED && cmd_q == CMD_C3) |=> !deeper_sleep_n;
  endproperty
  a_grant_deeper_sleep_n: assert property (p_grant_deeper_sleep_n) else $error("no deep sleep after grant");

  property p_c3_block;
    @(posedge clk) disable iff (rst)
      !proc_clock_stop_n |-> mem_access_block;
  endproperty
  a_c3_block: assert property (p_c3_block) else $error("memory open while stopped");

  property p_raise_first;
    @(posedge clk) disable iff (rst)
      $fell(low_voltage_req) |-> !proc_clock_stop_n;
  endproperty
  a_raise_first: assert property (p_raise_first) else $error("voltage raised too late");

  property p_s1_only;
    @(posedge clk) disable iff (rst)
      (st_q == ST_SLEEP && cmd_q == CMD_S1) |-> deeper_sleep_n && proc_clock_stop_n;
  endproperty
  a_s1_only: assert property (p_s1_only) else $error("extra control in s1");

  property p_sleep_via_s1;
    @(posedge clk) disable iff (rst)
      !sleep_out_n |-> !stop_clock_request_n;
  endproperty
  a_sleep_via_s1: assert property (p_sleep_via_s1) else $error("sleep without stop clock");

  property p_clocks;
    @(posedge clk) disable iff (rst)
      (st_q == ST_SUSPEND) |-> clocks_stopped;
  endproperty
  a_clocks: assert property (p_clocks) else $error("clocks run in suspend");

  property p_stay_off;
    @(posedge clk) disable iff (rst)
      ctrl_q[CTRL_AFTER_G3] |=> !resume_to_s0;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("resume while told to stay off");

  c_handshake: cover property (@(posedge clk) disable iff (rst) clr_write ##1 !ignore_error_out_n);
  c_c3:        cover property (@(posedge clk) disable iff (rst) !proc_clock_stop_n);
  c_c4:        cover property (@(posedge clk) disable iff (rst) low_voltage_req);
  c_suspend:   cover property (@(posedge clk) disable iff (rst) clocks_stopped);
  c_throttle:  cover property (@(posedge clk) disable iff (rst) throttle_q && st_q == ST_GRANTED);
endmodule : processor_sideband_control
`default_nettype wire

//--- sideband_pkg.sv
`default_nettype none
package sideband_pkg;
  localparam logic [7:0] ADDR_W = 8'h08;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CLEAR  = 8'h0c;
  localparam int CTRL_COPROC_EN = 1;
  localparam int CTRL_NMI_SCI   = 11;
  localparam int CTRL_AFTER_G3  = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_C0 = 3'h0;
  localparam logic [2:0] CMD_C2 = 3'h2;
  localparam logic [2:0] CMD_C3 = 3'h3;
  localparam logic [2:0] CMD_C4 = 3'h4;
  localparam logic [2:0] CMD_S1 = 3'h5;
  localparam logic [2:0] CMD_S3 = 3'h6;
  localparam int STEP_W = 4;
  localparam logic [3:0] STEP_GAP_CYC = 4'h2;
  localparam logic [3:0] THROTTLE_CYC = 4'h8;
  typedef enum logic [3:0] {
    ST_C0, ST_STOP_CLOCK_REQUEST_N, ST_GRANTED, ST_DEEPER_SLEEP_N, ST_STOPCPU, ST_LOWV,
    ST_RAISEV, ST_CLKRUN, ST_DEEPER_SLEEP_N_OFF, ST_SLEEP, ST_SUSPEND
  } pm_state_t;
endpackage : sideband_pkg
`default_nettype wire

//--- proc_partner.sv
`default_nettype none
module proc_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stop_clock_request_n,
  input  wire logic       err_req,
  input  wire logic [3:0] grant_dly,
  output var  logic       stop_grant_seen,
  output var  logic       numeric_error_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       done_q;
  always_ff @(posedge clk) numeric_error_in_n <= !err_req;
  // Hub forwards one grant per request; core stays halted meanwhile
  always_ff @(posedge clk) begin
    if (rst || stop_clock_request_n) begin
      cnt_q <= 4'h0;
      done_q <= 1'h0;
      stop_grant_seen <= 1'h0;
    end else begin
      stop_grant_seen <= !done_q && cnt_q == grant_dly;
      if (cnt_q == grant_dly) done_q <= 1'h1;
      else cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : proc_partner
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sideband_pkg::*;
  logic        clk, rst, reg_write, reg_read, io_write, err_req, serr_internal, serr_pin_n;
  logic        serr_hub_msg, iochk_serial, platform_power_ok, regulator_power_good;
  logic        stop_grant_seen, break_event, power_returned, numeric_error_in_n;
  logic        ignore_error_out_n, internal_irq_thirteen, nmi_out, sci_out, proc_power_good_out;
  logic        stop_clock_request_n, deeper_sleep_n, proc_clock_stop_n, low_voltage_req;
  logic        sleep_out_n, mem_access_block, clocks_stopped, resume_to_s0, seen;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] io_addr;
  logic [3:0]  grant_dly;
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  processor_sideband_control i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .io_write, .io_addr, .numeric_error_in_n, .ignore_error_out_n,
    .internal_irq_thirteen, .serr_internal, .serr_pin_n, .serr_hub_msg, .iochk_serial, .nmi_out,
    .sci_out, .platform_power_ok, .regulator_power_good, .proc_power_good_out, .stop_grant_seen,
    .break_event, .power_returned, .stop_clock_request_n, .deeper_sleep_n, .proc_clock_stop_n,
    .low_voltage_req, .sleep_out_n, .mem_access_block, .clocks_stopped, .resume_to_s0);
  proc_partner i_partner (.clk, .rst, .stop_clock_request_n, .err_req, .grant_dly,
    .stop_grant_seen, .numeric_error_in_n);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    $display("Checks %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Ceiling sits well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      finish_test;
    end
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1;
    chk(reg_rdata === e, "read");
  endtask : rd
  // One-cycle pulse: 0 break, 1 power back, else clear-port write
  task automatic pls(input int s);
    @(posedge clk);
    if (s == 0) break_event <= 1'h1;
    else if (s == 1) power_returned <= 1'h1;
    else io_write <= 1'h1;
    @(posedge clk);
    {break_event, power_returned, io_write} <= 3'h0;
  endtask : pls
  function automatic logic pick(input int s);
    case (s)
      0: return proc_clock_stop_n;
      1: return deeper_sleep_n;
      default: return stop_clock_request_n;
    endcase
  endfunction : pick
  task automatic wt(input int s, input logic v);
    for (int i = 0; i < 60 && pick(s) !== v; i++) cyc(1);
    chk(pick(s) === v, "wait");
  endtask : wt
  task automatic t_err;
    wr(OFF_CTRL, 32'h2);
    rd(OFF_CTRL, 32'h2);
    err_req <= 1'h1;
    cyc(4);
    chk(internal_irq_thirteen === 1'h1 && ignore_error_out_n === 1'h1, "irq");
    pls(2);
    #1;
    chk(internal_irq_thirteen === 1'h0 && ignore_error_out_n === 1'h0, "ign");
    cyc(5);
    chk(ignore_error_out_n === 1'h0, "hold");
    err_req <= 1'h0;
    cyc(4);
    chk(ignore_error_out_n === 1'h1, "drop");
    wr(OFF_CTRL, 32'h0);
    err_req <= 1'h1;
    cyc(4);
    chk(internal_irq_thirteen === 1'h0, "off irq");
    pls(2);
    cyc(2);
    chk(ignore_error_out_n === 1'h1, "off ign");
    err_req <= 1'h0;
    $display("Test error handshake done");
  endtask : t_err
  task automatic t_nmi;
    for (int r = 0; r < 2; r++) begin
      wr(OFF_CTRL, r ? 32'h800 : 32'h0);
      for (int s = 0; s < 4; s++) begin
        serr_internal <= (s == 0);
        serr_pin_n <= (s != 1);
        serr_hub_msg <= (s == 2);
        iochk_serial <= (s == 3);
        cyc(3);
        chk(nmi_out === (r == 0) && sci_out === (r == 1), "route");
        {serr_internal, serr_hub_msg, iochk_serial, serr_pin_n} <= 4'h1;
        cyc(3);
        chk(nmi_out === 1'h0 && sci_out === 1'h0, "idle");
      end
    end
    for (int k = 0; k < 4; k++) begin
      {regulator_power_good, platform_power_ok} <= k[1:0];
      cyc(2);
      chk(proc_power_good_out === (k[0] & k[1]), "pg");
    end
    $display("Test routing and power good done");
  endtask : t_nmi
  task automatic t_cst(input logic [2:0] c, input logic [3:0] d);
    grant_dly <= d;
    wr(OFF_CMD, {29'h0, c});
    wt(2, 1'h0);
    if (c == CMD_C2) begin
      cyc(12);
      chk(deeper_sleep_n === 1'h1 && stop_clock_request_n === 1'h0, "c2");
    end else begin
      wt(0, 1'h0);
      chk(deeper_sleep_n === 1'h0 && mem_access_block === 1'h1, "c3");
      chk(low_voltage_req === 1'h0, "early volt");
      cyc(6);
      chk(low_voltage_req === (c == CMD_C4), "volt");
    end
    wr(OFF_CMD, {29'h0, CMD_C0});
    pls(0);
    if (c != CMD_C2) begin
      wt(0, 1'h1);
      chk(low_voltage_req === 1'h0 && deeper_sleep_n === 1'h0, "exit");
    end
    wt(2, 1'h1);
    chk(deeper_sleep_n === 1'h1 && mem_access_block === 1'h0, "c0");
    $display("Test c-state %0d done", c);
  endtask : t_cst
  task automatic t_sleep;
    wr(OFF_CMD, 32'h8);
    wt(2, 1'h0);
    wt(2, 1'h1);
    wr(OFF_CMD, {29'h0, CMD_S1});
    wt(2, 1'h0);
    cyc(8);
    chk(sleep_out_n & deeper_sleep_n & proc_clock_stop_n & !stop_clock_request_n, "s1");
    wr(OFF_CMD, {29'h0, CMD_C0});
    pls(0);
    wt(2, 1'h1);
    for (int e = 0; e < 2; e++) begin
      wr(OFF_CTRL, e ? 32'h1 : 32'h0);
      wr(OFF_CMD, {29'h0, CMD_S3});
      wt(2, 1'h0);
      cyc(10);
      chk(sleep_out_n === 1'h0 && clocks_stopped === 1'h1, "s3");
      wr(OFF_CMD, {29'h0, CMD_C0});
      pls(1);
      wt(2, 1'h1);
      cyc(4);
      pls(1);
      #1 seen = resume_to_s0;
      repeat (10) begin
        cyc(1);
        seen = seen | resume_to_s0;
      end
      chk(seen === (e == 0), "resume");
    end
    $display("Test sleep states done");
  endtask : t_sleep
  initial begin
    {reg_write, reg_read, io_write, err_req, serr_internal, serr_hub_msg} = 6'h0;
    {iochk_serial, break_event, power_returned, reg_addr, reg_wdata} = 43'h0;
    {serr_pin_n, platform_power_ok, regulator_power_good, rst} = 4'hf;
    io_addr = 16'h00f0;
    grant_dly = 4'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rd(OFF_CTRL, CTRL_RESET);
    rd(8'h40, 32'h0);
    t_err;
    t_nmi;
    t_cst(CMD_C2, 4'h1);
    t_cst(CMD_C3, 4'h9);
    t_cst(CMD_C4, 4'h0);
    t_sleep;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
